/* rtl/pwm_cfg.svh */
// Constants for the speech pulse width modulator
`ifndef PWM_CFG_SVH
`define PWM_CFG_SVH
`define PAGE_HI 8'hff
`define ADDR_CTRL 16'hffe0
`define ADDR_ADJ 16'hffe1
`define ADDR_DATA 16'hffe2
`define ADDR_IRQ 16'hfffe
`define ADDR_IMR 16'hfffd
`define CTRL_EN_BIT 4
`define CTRL_FADJ_BIT 3
`define CTRL_RESET 5'h00
`define ADJ_RESET 8'h00
`define DATA_RESET 8'h00
`define SLOT_BASE 9'h100
`define SLOT_ADJ_BASE 10'h200
`define PERIOD_BASE 4'h8
`define FIFO_DEPTH 16
`define FIFO_AW 4
`endif

/* rtl/pwm_pkg.sv */
// Types for the speech pulse width modulator
package pwm_pkg;
	typedef struct packed {
		logic en;
		logic fadj;
		logic [2:0] period;
	} ctrl_t;
	typedef struct packed {
		logic first;
		logic second;
	} pulse_t;
	typedef enum logic [0:0] {
		PH_PULSE = 1'b0,
		PH_WAIT = 1'b1
	} phase_t;
endpackage

/* rtl/sample_fifo.sv */
// Parameterised sample FIFO with registered read data
`timescale 1ns/1ns
module sample_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ff;
	logic [AW-1:0] rd_ff;
	logic [AW:0] cnt_ff;
	logic out_valid_ff;
	logic [WIDTH-1:0] out_data_ff;
	logic push;
	logic pop;
	logic load;

	assign in_ready = (cnt_ff != (AW+1)'(DEPTH));
	assign push = in_valid && in_ready;
	// Output register refills when it is empty or being taken and memory holds an entry
	assign load = (cnt_ff != '0) && (!out_valid_ff || out_ready);
	assign pop = load;
	assign out_valid = out_valid_ff;
	assign out_data = out_data_ff;

	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ff] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			wr_ff <= '0;
			rd_ff <= '0;
			cnt_ff <= '0;
		end else begin
			if (push) begin
				wr_ff <= wr_ff + 1'b1;
			end
			if (pop) begin
				rd_ff <= rd_ff + 1'b1;
			end
			cnt_ff <= cnt_ff + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			out_valid_ff <= 1'b0;
			out_data_ff <= '0;
		end else if (load) begin
			out_valid_ff <= 1'b1;
			out_data_ff <= mem[rd_ff];
		end else if (out_ready) begin
			out_valid_ff <= 1'b0;
		end
	end

	chk_no_overflow: assert property (@(posedge clk) disable iff (rst)
		cnt_ff <= (AW+1)'(DEPTH))
		else $error("fifo count above depth");
endmodule

/* rtl/speech_pwm.sv */
// Speech pulse width modulator with internal data-space registers
// ---------------------------------------------------------------
// Summary of operation
// - Registers decoded inside last data page; never forwarded to external bus.
// - Control at ffe0, adjust at ffe1 write-only; sample at ffe2 read/write.
// - Sample timing divides only the oscillator 1 clock.
// - Control bits 2:0 give code S; rate goes as 1/(8-S).
// - Adjust off: one sample per 256*(8-S) oscillator cycles.
// - Adjust on: period becomes (512-A)*(8-S) oscillator cycles.
// - Adjust on: (256-A) wait slots appended to each period.
// - Active output held low throughout the wait slots.
// - Adjust value treated as 8-bit unsigned over full range.
// - Control bit 4 enables both outputs; clear disables them.
// - Sample bit 7 low: first output pulses, largest at 00h.
// - Sample bit 7 high: second output pulses, largest at ffh.
// - Duty pattern generated exactly once per sample period.
// - Request flag set at every period end, new data or not.
// - Without new writes, previous sample repeats every period.
// - New sample used from next period: one period latency.
// - Reset clears adjust, sample and control fields.
// - Completion flag in request bit 4, forwarded only when masked in.
// - Writing one never sets a request bit; writing zero clears it unless a period ends in that cycle.
// ---------------------------------------------------------------
`timescale 1ns/1ns
`include "pwm_cfg.svh"
module speech_pwm (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic [15:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	output logic INTERNAL_HIT,
	output logic EXT_STROBE_EN,
	output logic FIRST_PULSE_OUTPUT,
	output logic SECOND_PULSE_OUTPUT,
	output logic COMPLETION_REQUEST_FLAG,
	output logic SAMPLE_DONE_REQUEST,
	output logic SAMPLE_FULL
);
	// ---------------------------------------------------------------
	// Register decode
	// ---------------------------------------------------------------
	pwm_pkg::ctrl_t ctrl_ff;
	logic [7:0] adj_ff;
	logic [7:0] sample_ff;
	logic [7:0] active_ff;
	logic req_ff;
	logic mask_ff;
	logic [7:0] rdata_ff;
	logic hit_ctrl;
	logic hit_adj;
	logic hit_data;
	logic hit_irq;
	logic hit_imr;
	logic period_end;

	// Whole last page counts as internal so external parts never alias
	assign INTERNAL_HIT = (ADDR[15:8] == `PAGE_HI);
	assign EXT_STROBE_EN = (WR || RD) && !INTERNAL_HIT;
	assign hit_ctrl = ADDR == `ADDR_CTRL;
	assign hit_adj = ADDR == `ADDR_ADJ;
	assign hit_data = ADDR == `ADDR_DATA;
	assign hit_irq = ADDR == `ADDR_IRQ;
	assign hit_imr = ADDR == `ADDR_IMR;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ctrl_ff <= `CTRL_RESET;
		end else if (WR && hit_ctrl) begin
			ctrl_ff <= WDATA[4:0];
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			adj_ff <= `ADJ_RESET;
		end else if (WR && hit_adj) begin
			adj_ff <= WDATA;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			sample_ff <= `DATA_RESET;
		end else if (WR && hit_data) begin
			sample_ff <= WDATA;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			mask_ff <= 1'b0;
		end else if (WR && hit_imr) begin
			mask_ff <= WDATA[4];
		end
	end

	// Set wins over a same-cycle clear so no completion is lost
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			req_ff <= 1'b0;
		end else if (period_end) begin
			req_ff <= 1'b1;
		end else if (WR && hit_irq && !WDATA[4]) begin
			req_ff <= 1'b0;
		end
	end

	assign COMPLETION_REQUEST_FLAG = req_ff;
	assign SAMPLE_DONE_REQUEST = req_ff && mask_ff;

	// Write-only registers read back as zero
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			rdata_ff <= 8'h00;
		end else if (RD) begin
			if (hit_data) begin
				rdata_ff <= sample_ff;
			end else if (hit_irq) begin
				rdata_ff <= {3'h0, req_ff, 4'h0};
			end else if (hit_imr) begin
				rdata_ff <= {3'h0, mask_ff, 4'h0};
			end else begin
				rdata_ff <= 8'h00;
			end
		end
	end
	assign RDATA = rdata_ff;

	// ---------------------------------------------------------------
	// Sample history FIFO
	// ---------------------------------------------------------------
	// Each period's latched sample is logged unless the FIFO is full; the reader drains it via RD
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic [7:0] fifo_out_data;

	sample_fifo #(
		.WIDTH(8),
		.DEPTH(`FIFO_DEPTH),
		.AW(`FIFO_AW)
	) u_hist (
		.clk(CLOCK),
		.rst(RST),
		.in_valid(period_end),
		.in_ready(fifo_in_ready),
		.in_data(sample_ff),
		.out_valid(fifo_out_valid),
		.out_ready(RD && hit_data),
		.out_data(fifo_out_data)
	);
	assign SAMPLE_FULL = !fifo_in_ready;

	// ---------------------------------------------------------------
	// Period timing
	// ---------------------------------------------------------------
	// CLOCK stands in for oscillator 1; no other source feeds the divider
	logic [2:0] pre_ff;
	logic [2:0] pre_lim;
	logic tick;
	logic [7:0] slot_ff;
	logic [8:0] wait_ff;
	pwm_pkg::phase_t phase_ff;

	// Prescale by (8-S): slot length sets the rate
	assign pre_lim = 3'h7 - ctrl_ff.period;
	assign tick = (pre_ff == pre_lim);

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			pre_ff <= 3'h0;
		end else if (tick) begin
			pre_ff <= 3'h0;
		end else begin
			pre_ff <= pre_ff + 3'h1;
		end
	end

	// Counter runs regardless of enable so re-enable is glitch free
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			phase_ff <= pwm_pkg::PH_PULSE;
			slot_ff <= 8'h00;
			wait_ff <= 9'h000;
		end else if (tick) begin
			case (phase_ff)
				pwm_pkg::PH_PULSE: begin
					slot_ff <= slot_ff + 8'h01;
					if (slot_ff == 8'hff && ctrl_ff.fadj) begin
						phase_ff <= pwm_pkg::PH_WAIT;
						wait_ff <= 9'h100 - {1'b0, adj_ff};
					end
				end
				pwm_pkg::PH_WAIT: begin
					wait_ff <= wait_ff - 9'h001;
					if (wait_ff == 9'h001) begin
						phase_ff <= pwm_pkg::PH_PULSE;
					end
				end
				default: begin
					phase_ff <= pwm_pkg::PH_PULSE;
				end
			endcase
		end
	end

	// Period ends on the last pulse slot (no adjust) or last wait slot
	assign period_end = tick && (
		(phase_ff == pwm_pkg::PH_PULSE && slot_ff == 8'hff
			&& !ctrl_ff.fadj)
		|| (phase_ff == pwm_pkg::PH_WAIT && wait_ff == 9'h001));

	// Latched once per period: writes take effect the period after
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			active_ff <= 8'h00;
		end else if (period_end) begin
			active_ff <= sample_ff;
		end
	end

	// ---------------------------------------------------------------
	// Pulse outputs
	// ---------------------------------------------------------------
	logic [6:0] mag;
	logic high;
	logic first_ff;
	logic second_ff;

	// Bit 7 low: smaller code is longer pulse; bit 7 high: larger is longer
	assign mag = active_ff[7] ? active_ff[6:0] : ~active_ff[6:0];
	assign high = (phase_ff == pwm_pkg::PH_PULSE)
		&& ({1'b0, slot_ff[7:1]} <= {1'b0, mag}) ;

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			first_ff <= 1'b0;
			second_ff <= 1'b0;
		end else begin
			first_ff <= ctrl_ff.en && high && !active_ff[7];
			second_ff <= ctrl_ff.en && high && active_ff[7];
		end
	end
	assign FIRST_PULSE_OUTPUT = first_ff;
	assign SECOND_PULSE_OUTPUT = second_ff;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	// Length checked only after a whole period free of setting writes
	logic [9:0] slots_per;
	logic [3:0] slot_len;
	logic [13:0] span_lim;
	logic [13:0] span_ff;
	logic steady_ff;

	assign slots_per = ctrl_ff.fadj
		? (`SLOT_ADJ_BASE - {2'b00, adj_ff}) : {1'b0, `SLOT_BASE};
	assign slot_len = `PERIOD_BASE - {1'b0, ctrl_ff.period};
	assign span_lim = {4'h0, slots_per} * {10'h000, slot_len};

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			span_ff <= 14'h0000;
		end else if (period_end) begin
			span_ff <= 14'h0000;
		end else begin
			span_ff <= span_ff + 14'h0001;
		end
	end

	always_ff @(posedge CLOCK) begin
		if (RST) begin
			steady_ff <= 1'b0;
		end else if (WR && (hit_ctrl || hit_adj)) begin
			steady_ff <= 1'b0;
		end else if (period_end) begin
			steady_ff <= 1'b1;
		end
	end

	chk_wait_quiet: assert property (
		@(posedge CLOCK) disable iff (RST)
		phase_ff == pwm_pkg::PH_WAIT |=> !first_ff && !second_ff)
		else $error("output active during wait slots");
	chk_disable_quiet: assert property (
		@(posedge CLOCK) disable iff (RST)
		!ctrl_ff.en |=> !first_ff && !second_ff)
		else $error("output active while disabled");
	chk_one_side: assert property (
		@(posedge CLOCK) disable iff (RST)
		!(first_ff && second_ff))
		else $error("both outputs active");
	chk_sign_first: assert property (
		@(posedge CLOCK) disable iff (RST)
		active_ff[7] |=> !first_ff)
		else $error("first output active with bit 7 set");
	chk_req_set: assert property (
		@(posedge CLOCK) disable iff (RST)
		period_end |=> req_ff)
		else $error("request not set at period end");
	chk_req_no_set: assert property (
		@(posedge CLOCK) disable iff (RST)
		!req_ff && !period_end |=> !req_ff)
		else $error("request set without period end");
	chk_req_gate: assert property (
		@(posedge CLOCK) disable iff (RST)
		SAMPLE_DONE_REQUEST |-> mask_ff)
		else $error("request forwarded while masked");
	chk_latency: assert property (
		@(posedge CLOCK) disable iff (RST)
		period_end |=> active_ff == $past(sample_ff))
		else $error("sample not taken at period end");
	chk_hold: assert property (
		@(posedge CLOCK) disable iff (RST)
		!period_end |=> $stable(active_ff))
		else $error("active sample changed mid period");
	chk_wait_len: assert property (
		@(posedge CLOCK) disable iff (RST)
		$rose(phase_ff == pwm_pkg::PH_WAIT)
		|-> wait_ff == 9'h100 - {1'b0, $past(adj_ff)})
		else $error("wait slot count wrong");
	chk_ext_block: assert property (
		@(posedge CLOCK) disable iff (RST)
		INTERNAL_HIT |-> !EXT_STROBE_EN)
		else $error("internal access forwarded");
	chk_period_len: assert property (
		@(posedge CLOCK) disable iff (RST)
		period_end && steady_ff |-> span_ff == span_lim - 14'h0001)
		else $error("sample period length wrong");
	chk_hist_first: assert property (
		@(posedge CLOCK) disable iff (RST)
		period_end && !fifo_out_valid
		|-> ##2 fifo_out_data == active_ff)
		else $error("history entry differs from latched sample");
	chk_rd_sample: assert property (
		@(posedge CLOCK) disable iff (RST)
		RD && hit_data |=> RDATA == $past(sample_ff))
		else $error("sample read back wrong");
	chk_ctrl_write: assert property (
		@(posedge CLOCK) disable iff (RST)
		WR && hit_ctrl |=> ctrl_ff == $past(WDATA[4:0]))
		else $error("control write not stored");
	chk_adj_write: assert property (
		@(posedge CLOCK) disable iff (RST)
		WR && hit_adj |=> adj_ff == $past(WDATA))
		else $error("adjust write not stored");
	chk_free_run: assert property (
		@(posedge CLOCK) disable iff (RST)
		!ctrl_ff.en && !tick |=> pre_ff == $past(pre_ff) + 3'h1)
		else $error("prescaler stalled while disabled");

	cov_period: cover property (@(posedge CLOCK) disable iff (RST)
		period_end);
	cov_wait: cover property (@(posedge CLOCK) disable iff (RST)
		phase_ff == pwm_pkg::PH_WAIT);
	cov_second: cover property (@(posedge CLOCK) disable iff (RST)
		second_ff);
	cov_clear: cover property (@(posedge CLOCK) disable iff (RST)
		req_ff ##1 !req_ff);
	cov_hist_full: cover property (@(posedge CLOCK) disable iff (RST)
		!fifo_in_ready);
endmodule

/* dv/pwm_speaker_model.sv */
// Speaker model that integrates the two pulse outputs
`timescale 1ns/1ns
module pwm_speaker_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic first,
	input wire logic second,
	output logic [15:0] first_cnt,
	output logic [15:0] second_cnt,
	output logic overlap
);
	// Free-running totals; the bench takes differences per period
	always_ff @(posedge clk) begin
		if (rst) begin
			first_cnt <= 16'h0000;
			second_cnt <= 16'h0000;
			overlap <= 1'b0;
		end else begin
			first_cnt <= first_cnt + {15'h0000, first === 1'b1};
			second_cnt <= second_cnt + {15'h0000, second === 1'b1};
			// Both ends high at once would short the coil
			overlap <= overlap | (first & second);
		end
	end
endmodule

/* dv/speech_pulse_width_modulator_tb_top.sv */
// Self-checking bench for the speech pulse width modulator
`timescale 1ns/1ns
module speech_pulse_width_modulator_tb_top;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [15:0] addr = 16'h0000;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [7:0] rdata, rv;
	logic hit, ext_en, p1, p2, flag, req, full, ovl;
	logic [15:0] cnt1, cnt2, a1, a2, c1, c2, c00, cff;
	int num_errors = 0;
	int total_checks = 0;
	int cyc = 0;
	int t0, per;
	always #10 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;
	speech_pwm u_dut (.CLOCK(clock), .RST(rst), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
		.INTERNAL_HIT(hit), .EXT_STROBE_EN(ext_en),
		.FIRST_PULSE_OUTPUT(p1), .SECOND_PULSE_OUTPUT(p2),
		.COMPLETION_REQUEST_FLAG(flag), .SAMPLE_DONE_REQUEST(req),
		.SAMPLE_FULL(full));
	pwm_speaker_model u_spk (.clk(clock), .rst(rst), .first(p1),
		.second(p2), .first_cnt(cnt1), .second_cnt(cnt2),
		.overlap(ovl));
	// --------------------------------
	// Tasks
	// --------------------------------
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d errors=%0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic wait_flag();
		int n;
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
		end while (flag !== 1'b1 && n < 5000);
		if (n >= 5000) begin
			num_errors++;
			give_verdict();
		end
	endtask
	// Measures one whole period between two request rises
	// First rise only syncs: one landing on the clearing write shows late
	task automatic meas();
		for (int k = 0; k < 3; k++) begin
			wr_reg(16'hfffe, 8'hef);
			wait_flag();
			if (k == 2) begin
				per = cyc - t0;
				c1 = cnt1 - a1;
				c2 = cnt2 - a2;
			end
			t0 = cyc;
			a1 = cnt1;
			a2 = cnt2;
		end
	endtask
	// --------------------------------
	// Main sequence
	// --------------------------------
	initial begin
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		rd_reg(16'hffe2, rv);
		chk(rv, 8'h00);
		rd_reg(16'hffe0, rv);
		chk(rv, 8'h00);
		chk({p1, p2, flag, req, full}, 5'h00);
		@(posedge clock);
		addr <= 16'h1234;
		wr <= 1'b1;
		#1 chk({hit, ext_en}, 2'b01);
		@(posedge clock);
		addr <= 16'hffe1;
		wdata <= 8'h00;
		#1 chk({hit, ext_en}, 2'b10);
		@(posedge clock);
		wr <= 1'b0;
		$display("reset and decode done");
		// Bits 7:5 set on purpose and must be dropped; bit 4 is kept as enable
		for (int s = 7; s >= 6; s--) begin
			wr_reg(16'hffe0, 8'hf0 | 8'(s));
			meas();
			chk(16'(per), 16'(256 * (8 - s)));
		end
		$display("period code done");
		wr_reg(16'hffe0, 8'h17);
		wr_reg(16'hffe2, 8'h00);
		meas();
		c00 = c1;
		chk(c2, 16'h0000);
		chk(c00 != 0, 1'b1);
		meas();
		chk(c1, c00);
		wr_reg(16'hffe2, 8'h40);
		meas();
		chk({c1 < c00, c2}, 17'h10000);
		wr_reg(16'hffe2, 8'hff);
		meas();
		cff = c2;
		chk({cff != 0, c1}, 17'h10000);
		wr_reg(16'hffe2, 8'h80);
		meas();
		chk({c2 < cff, c1}, 17'h10000);
		wr_reg(16'hffe2, 8'h00);
		wr_reg(16'hfffe, 8'hef);
		wait_flag();
		chk(16'(cnt1 - a1), 16'h0000);
		chk(ovl, 1'b0);
		$display("sample patterns done");
		for (int i = 0; i < 3; i++) begin
			wr_reg(16'hffe1, i == 0 ? 8'hff : (i == 1 ? 8'hfe : 8'h00));
			wr_reg(16'hffe0, 8'h1f);
			meas();
			chk(16'(per), i == 0 ? 16'd257 : (i == 1 ? 16'd258 : 16'd512));
		end
		chk(c1, c00);
		wr_reg(16'hffe0, 8'h07);
		meas();
		chk({c1 | c2, 16'(per)}, {16'h0000, 16'd256});
		$display("adjust and enable done");
		wr_reg(16'hfffd, 8'h10);
		#1 chk({flag, req}, 2'b11);
		wr_reg(16'hfffd, 8'h00);
		#1 chk(req, 1'b0);
		wr_reg(16'hfffe, 8'hef);
		wr_reg(16'hfffe, 8'hff);
		#1 chk(flag, 1'b0);
		$display("request flag done");
		repeat (17) rd_reg(16'hffe2, rv);
		chk(full, 1'b0);
		repeat (17) begin
			wr_reg(16'hfffe, 8'hef);
			wait_flag();
		end
		chk(full, 1'b1);
		repeat (16) begin
			rd_reg(16'hffe2, rv);
			chk(rv, 8'h00);
		end
		chk(full, 1'b0);
		$display("history buffer done");
		give_verdict();
	end
endmodule
